// file: core/event_cfg_pkg.sv
package event_cfg_pkg;

    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0]  GENERAL_IDX        = 8'h1C;
    localparam logic [7:0]  CAPTURE_COUNT_IDX  = 8'h1D;
    localparam logic [7:0]  HYSTERESIS_IDX     = 8'h1F;
    localparam logic [7:0]  HIGH_THRESHOLD_IDX = 8'h21;
    localparam logic [7:0]  LOW_THRESHOLD_IDX  = 8'h23;
    localparam logic [7:0]  OFFSET_IDX         = 8'h25;
    localparam logic [7:0]  STATUS_IDX         = 8'h30;
    localparam logic [7:0]  STATUS_CLEAR_IDX   = 8'h31;
    localparam logic [7:0]  IRQ_ENABLE_IDX     = 8'h32;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int unsigned EVENT_EN_BIT       = 7;
    localparam int unsigned HIGH_ROUTE_BIT     = 6;
    localparam int unsigned LOW_ROUTE_BIT      = 5;
    localparam int unsigned CNV_ERR_ROUTE_BIT  = 4;
    localparam int unsigned FIFO_MODE_LSB      = 0;
    localparam int unsigned FIFO_MODE_W        = 2;
    localparam int unsigned CAPTURE_W          = 15;
    localparam int unsigned HYSTERESIS_W       = 11;
    localparam int unsigned THRESHOLD_W        = 12;
    localparam int unsigned OFFSET_W           = 12;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [7:0]  GENERAL_RESET      = 8'h00;
    localparam logic [14:0] CAPTURE_RESET      = 15'h4000;
    localparam logic [15:0] CAPTURE_MIN        = 16'h0001;
    localparam logic [15:0] CAPTURE_MAX        = 16'h4000;
    localparam logic [10:0] HYSTERESIS_RESET   = 11'h000;
    localparam logic [11:0] THRESHOLD_RESET    = 12'h000;
    localparam logic [11:0] OFFSET_RESET       = 12'h000;

    // ------------------------------------------------------------
    // Status / interrupt bits
    // ------------------------------------------------------------
    localparam int unsigned ST_HIGH            = 0;
    localparam int unsigned ST_LOW             = 1;
    localparam int unsigned ST_CNV_ERR         = 2;
    localparam int unsigned ST_EVENT_ADDR      = 3;
    localparam int unsigned STATUS_W           = 4;
    localparam logic [3:0]  STATUS_RESET       = 4'h0;

    typedef enum logic [1:0] {
        FIFO_OFF,
        FIFO_IMMEDIATE,
        FIFO_EVENT_LATEST,
        FIFO_EVENT_ALL
    } fifo_mode_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_READ
    } bus_state_t;

endpackage

// file: core/sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic set,
    input  wire logic clear,
    output logic      flag
);
    // Set wins so an event in the clearing cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end
endmodule

// file: core/limit_detector.sv
`timescale 1ns/1ps
module limit_detector #(
    parameter bit UPPER = 1'b1
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              enable,
    input  wire logic              sample_valid,
    input  wire logic signed [11:0] sample,
    input  wire logic signed [11:0] limit,
    input  wire logic [10:0]       hysteresis,
    output logic                   detect
);
    logic signed [13:0] s_ext;
    logic signed [13:0] l_ext;
    logic signed [13:0] h_ext;
    logic               trip;
    logic               release_lvl;

    assign s_ext = 14'(sample);
    assign l_ext = 14'(limit);
    assign h_ext = $signed({3'b000, hysteresis});
    // Wide arithmetic: limit plus hysteresis may leave the 12-bit range
    assign trip        = UPPER ? (s_ext > l_ext) : (s_ext < l_ext);
    assign release_lvl = UPPER ? (s_ext < l_ext - h_ext) : (s_ext > l_ext + h_ext);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            detect <= 1'b0;
        end else if (!enable) begin
            detect <= 1'b0;
        end else if (sample_valid && trip) begin
            detect <= 1'b1;
        end else if (sample_valid && release_lvl) begin
            detect <= 1'b0;
        end
    end
endmodule

// file: core/event_fifo_config_regs.sv
`timescale 1ns/1ps
module event_fifo_config_regs (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        result_valid,
    input  wire logic [11:0] result_data,
    input  wire logic        conversion_error,
    input  wire logic        capture_done,
    input  wire logic [14:0] fifo_event_addr,
    output logic             event_detect_enable,
    output logic             high_detect,
    output logic             low_detect,
    output logic             fifo_high_event,
    output logic             fifo_low_event,
    output logic [1:0]       fifo_mode,
    output logic [14:0]      capture_count,
    output logic [10:0]      hysteresis,
    output logic [11:0]      upper_limit_value,
    output logic [11:0]      lower_limit_value,
    output logic [11:0]      offset_coeff,
    output logic             alert_n,
    output logic             irq
);

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    event_cfg_pkg::bus_state_t bus_state;
    logic        addr_phase;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [7:0]  rd_idx;
    logic        wr_en;
    logic [31:0] read_word;

    assign addr_phase = hsel && hready && htrans[1];
    assign wr_en      = wr_pend;

    // Only whole-word accesses are expected; hsize is not checked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx  <= 8'h00;
        end else begin
            wr_pend <= addr_phase && hwrite;
            if (addr_phase && hwrite) begin
                wr_idx <= haddr[9:2];
            end
        end
    end

    // One wait state on reads so hrdata is a flop and sees prior writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= event_cfg_pkg::BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata    <= 32'h00000000;
            rd_idx    <= 8'h00;
        end else begin
            unique case (bus_state)
                event_cfg_pkg::BUS_IDLE: begin
                    if (addr_phase && !hwrite) begin
                        bus_state <= event_cfg_pkg::BUS_READ;
                        hreadyout <= 1'b0;
                        rd_idx    <= haddr[9:2];
                    end
                end
                event_cfg_pkg::BUS_READ: begin
                    bus_state <= event_cfg_pkg::BUS_IDLE;
                    hreadyout <= 1'b1;
                    hrdata    <= read_word;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // General control register
    // ------------------------------------------------------------
    logic high_detect_route;
    logic low_detect_route;
    logic conversion_error_route;
    logic mode_write;

    assign mode_write = wr_en && (wr_idx == event_cfg_pkg::GENERAL_IDX);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_detect_enable    <= event_cfg_pkg::GENERAL_RESET[event_cfg_pkg::EVENT_EN_BIT];
            high_detect_route      <= event_cfg_pkg::GENERAL_RESET[event_cfg_pkg::HIGH_ROUTE_BIT];
            low_detect_route       <= event_cfg_pkg::GENERAL_RESET[event_cfg_pkg::LOW_ROUTE_BIT];
            conversion_error_route <=
                event_cfg_pkg::GENERAL_RESET[event_cfg_pkg::CNV_ERR_ROUTE_BIT];
            fifo_mode              <= event_cfg_pkg::GENERAL_RESET[1:0];
        end else if (mode_write) begin
            event_detect_enable    <= hwdata[event_cfg_pkg::EVENT_EN_BIT];
            high_detect_route      <= hwdata[event_cfg_pkg::HIGH_ROUTE_BIT];
            low_detect_route       <= hwdata[event_cfg_pkg::LOW_ROUTE_BIT];
            conversion_error_route <= hwdata[event_cfg_pkg::CNV_ERR_ROUTE_BIT];
            fifo_mode              <= hwdata[event_cfg_pkg::FIFO_MODE_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Capture count with clipping
    // ------------------------------------------------------------
    logic        count_write;
    logic [15:0] count_in;

    assign count_write = wr_en && (wr_idx == event_cfg_pkg::CAPTURE_COUNT_IDX);
    assign count_in    = hwdata[15:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_count <= event_cfg_pkg::CAPTURE_RESET;
        end else if (count_write) begin
            if (count_in < event_cfg_pkg::CAPTURE_MIN) begin
                capture_count <= event_cfg_pkg::CAPTURE_MIN[14:0];
            end else if (count_in > event_cfg_pkg::CAPTURE_MAX) begin
                capture_count <= event_cfg_pkg::CAPTURE_MAX[14:0];
            end else begin
                capture_count <= count_in[14:0];
            end
        end
    end

    // In FIFO_EVENT_ALL mode the event location is latched when the capture completes after the event
    logic        event_addr_valid;
    logic [14:0] event_addr;
    logic        whole_fifo_mode;

    assign whole_fifo_mode =
        (event_cfg_pkg::fifo_mode_t'(fifo_mode) == event_cfg_pkg::FIFO_EVENT_ALL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_addr_valid <= 1'b0;
            event_addr       <= 15'h0000;
        end else if (whole_fifo_mode && capture_done) begin
            event_addr_valid <= 1'b1;
            event_addr       <= fifo_event_addr;
        end else if (count_write || mode_write) begin
            // A new count or mode arms a fresh capture
            event_addr_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Threshold, hysteresis and offset registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hysteresis <= event_cfg_pkg::HYSTERESIS_RESET;
        end else if (wr_en && (wr_idx == event_cfg_pkg::HYSTERESIS_IDX)) begin
            hysteresis <= hwdata[10:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upper_limit_value <= event_cfg_pkg::THRESHOLD_RESET;
        end else if (wr_en && (wr_idx == event_cfg_pkg::HIGH_THRESHOLD_IDX)) begin
            upper_limit_value <= hwdata[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lower_limit_value <= event_cfg_pkg::THRESHOLD_RESET;
        end else if (wr_en && (wr_idx == event_cfg_pkg::LOW_THRESHOLD_IDX)) begin
            lower_limit_value <= hwdata[11:0];
        end
    end

    // Coefficient is handed to the correction stage outside this block
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            offset_coeff <= event_cfg_pkg::OFFSET_RESET;
        end else if (wr_en && (wr_idx == event_cfg_pkg::OFFSET_IDX)) begin
            offset_coeff <= hwdata[11:0];
        end
    end

    // ------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------
    limit_detector #(
        .UPPER (1'b1)
    ) u_high (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .enable       (event_detect_enable),
        .sample_valid (result_valid),
        .sample       ($signed(result_data)),
        .limit        ($signed(upper_limit_value)),
        .hysteresis   (hysteresis),
        .detect       (high_detect)
    );

    limit_detector #(
        .UPPER (1'b0)
    ) u_low (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .enable       (event_detect_enable),
        .sample_valid (result_valid),
        .sample       ($signed(result_data)),
        .limit        ($signed(lower_limit_value)),
        .hysteresis   (hysteresis),
        .detect       (low_detect)
    );

    logic high_routed;
    logic low_routed;
    logic error_routed;

    assign high_routed  = high_detect && high_detect_route;
    assign low_routed   = low_detect && low_detect_route;
    assign error_routed = conversion_error && conversion_error_route;

    // Conversion errors never feed the FIFO trigger
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_high_event <= 1'b0;
            fifo_low_event  <= 1'b0;
        end else begin
            fifo_high_event <= high_routed;
            fifo_low_event  <= low_routed;
        end
    end

    // Alert pin: low while any routed condition is present
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_n <= 1'b1;
        end else begin
            alert_n <= !(high_routed || low_routed || error_routed);
        end
    end

    // ------------------------------------------------------------
    // Status, clear and interrupt enable
    // ------------------------------------------------------------
    logic [3:0] status;
    logic [3:0] status_set;
    logic [3:0] status_clr;
    logic [3:0] irq_enable;

    assign status_set[event_cfg_pkg::ST_HIGH]       = high_routed;
    assign status_set[event_cfg_pkg::ST_LOW]        = low_routed;
    assign status_set[event_cfg_pkg::ST_CNV_ERR]    = error_routed;
    assign status_set[event_cfg_pkg::ST_EVENT_ADDR] = whole_fifo_mode && capture_done;
    assign status_clr = (wr_en && (wr_idx == event_cfg_pkg::STATUS_CLEAR_IDX)) ?
                        hwdata[3:0] : 4'h0;

    for (genvar i = 0; i < event_cfg_pkg::STATUS_W; i++) begin : g_status
        sticky_flag u_flag (
            .hclk    (hclk),
            .hresetn (hresetn),
            .set     (status_set[i]),
            .clear   (status_clr[i]),
            .flag    (status[i])
        );
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_enable <= event_cfg_pkg::STATUS_RESET;
        end else if (wr_en && (wr_idx == event_cfg_pkg::IRQ_ENABLE_IDX)) begin
            irq_enable <= hwdata[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & irq_enable);
        end
    end

    // ------------------------------------------------------------
    // Read mux; reserved bits and unmapped words read as zero
    // ------------------------------------------------------------
    always_comb begin
        read_word = 32'h00000000;
        unique case (rd_idx)
            event_cfg_pkg::GENERAL_IDX: begin
                read_word[event_cfg_pkg::EVENT_EN_BIT]      = event_detect_enable;
                read_word[event_cfg_pkg::HIGH_ROUTE_BIT]    = high_detect_route;
                read_word[event_cfg_pkg::LOW_ROUTE_BIT]     = low_detect_route;
                read_word[event_cfg_pkg::CNV_ERR_ROUTE_BIT] = conversion_error_route;
                read_word[1:0]                              = fifo_mode;
            end
            event_cfg_pkg::CAPTURE_COUNT_IDX: begin
                read_word[14:0] = (whole_fifo_mode && event_addr_valid) ?
                                  event_addr : capture_count;
            end
            event_cfg_pkg::HYSTERESIS_IDX: begin
                read_word[10:0] = hysteresis;
            end
            event_cfg_pkg::HIGH_THRESHOLD_IDX: begin
                read_word[11:0] = upper_limit_value;
            end
            event_cfg_pkg::LOW_THRESHOLD_IDX: begin
                read_word[11:0] = lower_limit_value;
            end
            event_cfg_pkg::OFFSET_IDX: begin
                read_word[11:0] = offset_coeff;
            end
            event_cfg_pkg::STATUS_IDX: begin
                read_word[3:0] = status;
            end
            event_cfg_pkg::IRQ_ENABLE_IDX: begin
                read_word[3:0] = irq_enable;
            end
            default: begin
                read_word = 32'h00000000;
            end
        endcase
    end

endmodule

// file: test/event_fifo_config_regs_chk.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port-level checks
// ------------------------------------------------------------
module event_fifo_config_regs_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        result_valid,
    input wire logic [11:0] result_data,
    input wire logic        conversion_error,
    input wire logic        event_detect_enable,
    input wire logic        high_detect,
    input wire logic        low_detect,
    input wire logic        fifo_high_event,
    input wire logic        fifo_low_event,
    input wire logic [1:0]  fifo_mode,
    input wire logic [14:0] capture_count,
    input wire logic [11:0] upper_limit_value,
    input wire logic [11:0] lower_limit_value,
    input wire logic        alert_n,
    input wire logic        irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_detect_off: assert property (
        !event_detect_enable [*2] |-> !(high_detect || low_detect))
        else $error("detection active while disabled");
    a_high_route: assert property (fifo_high_event |-> $past(high_detect))
        else $error("fifo high event without detection");
    a_low_route: assert property (fifo_low_event |-> $past(low_detect))
        else $error("fifo low event without detection");
    a_alert_cause: assert property (!alert_n |->
        $past(high_detect || low_detect || conversion_error) || $past(conversion_error, 2))
        else $error("alert without a cause");
    a_mode_write: assert property (
        $changed(fifo_mode) |-> $past(hsel && htrans[1] && hwrite, 2))
        else $error("fifo mode changed without a write");
    a_count_range: assert property (capture_count != 15'h0 && capture_count <= 15'h4000)
        else $error("capture count out of range");
    a_high_trip: assert property (event_detect_enable && result_valid
        && $signed(result_data) > $signed(upper_limit_value) |=> high_detect)
        else $error("high detection missed");
    a_low_trip: assert property (event_detect_enable && result_valid
        && $signed(result_data) < $signed(lower_limit_value) |=> low_detect)
        else $error("low detection missed");
    cover property (!alert_n);
    cover property (irq);
    cover property (fifo_high_event);
endmodule

// file: test/test_event_fifo_config_regs.sv
`timescale 1ns/1ps
module test_event_fifo_config_regs;
    typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, result_valid, capture_done;
    logic        conversion_error, event_detect_enable, high_detect, low_detect, alert_n, irq;
    logic        fifo_high_event, fifo_low_event;
    logic [1:0]  htrans, fifo_mode;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [11:0] result_data, upper_limit_value, lower_limit_value, offset_coeff;
    logic [14:0] fifo_event_addr, capture_count;
    logic [10:0] hysteresis;
    int          bad_count = 0;
    int          n_checks = 0;
    // Reserved bits of mapped registers are written as zeros, as the host must; the unmapped word at 0x40 is written with ones
    row_t        rows [9] = '{'{32'h70, 32'hF0, 32'hF0}, '{32'h74, 32'h0, 32'h1},
        '{32'h74, 32'h7FFF, 32'h4000}, '{32'h74, 32'h8, 32'h8}, '{32'h7C, 32'h7FF, 32'h7FF},
        '{32'h84, 32'h800, 32'h800}, '{32'h8C, 32'hFFF, 32'hFFF},
        '{32'h94, 32'h234, 32'h234}, '{32'h40, 32'hFFFF, 32'h0}};

    event_fifo_config_regs dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .result_valid(result_valid),
        .result_data(result_data), .conversion_error(conversion_error),
        .capture_done(capture_done), .fifo_event_addr(fifo_event_addr),
        .event_detect_enable(event_detect_enable), .high_detect(high_detect),
        .low_detect(low_detect), .fifo_high_event(fifo_high_event),
        .fifo_low_event(fifo_low_event), .fifo_mode(fifo_mode),
        .capture_count(capture_count), .hysteresis(hysteresis),
        .upper_limit_value(upper_limit_value), .lower_limit_value(lower_limit_value),
        .offset_coeff(offset_coeff), .alert_n(alert_n), .irq(irq));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for hready sampled high at a rising edge
    task wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (i >= 50) begin
            bad_count++;
            close_out;
        end
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
    endtask

    // Detector answers one edge late, routing one more and irq two more
    task smp(input logic [11:0] v);
        @(posedge hclk);
        result_valid <= 1'b1;
        result_data  <= v;
        @(posedge hclk);
        result_valid <= 1'b0;
        repeat (3) @(posedge hclk);
        #1;
    endtask

    task rst;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    initial begin
        {hsel, hwrite, result_valid, capture_done, conversion_error, hresetn} = 6'h0;
        {htrans, haddr, hwdata, result_data, fifo_event_addr} = '0;
        rst;
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            chk(r, rows[i].e);
        end
        chk({hresp, event_detect_enable, hysteresis}, 13'h0FFF);
        chk({upper_limit_value, lower_limit_value}, 24'h800FFF);
        chk(offset_coeff, 12'h234);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 32'h70, 32'(m));
            #1;
            chk(fifo_mode, 32'(m));
        end
        bus(1'b1, 32'h7C, 32'hA);
        bus(1'b1, 32'h84, 32'h64);
        bus(1'b1, 32'h8C, 32'hF9C);
        bus(1'b1, 32'hC8, 32'hF);
        bus(1'b1, 32'h70, 32'h70);
        smp(12'h0C8);
        chk(high_detect, 1'b0);
        bus(1'b1, 32'h70, 32'hF0);
        smp(12'h0C8);
        chk({high_detect, fifo_high_event, alert_n, irq}, 4'hD);
        bus(1'b0, 32'hC0, 32'h0);
        chk(r, 32'h1);
        smp(12'h05F);
        chk(high_detect, 1'b1);
        smp(12'h050);
        chk({high_detect, alert_n}, 2'h1);
        bus(1'b1, 32'hC4, 32'hF);
        bus(1'b0, 32'hC0, 32'h0);
        chk(r, 32'h0);
        chk(irq, 1'b0);
        bus(1'b1, 32'h70, 32'h80);
        smp(12'hF38);
        chk({low_detect, fifo_low_event, alert_n, irq}, 4'hA);
        bus(1'b0, 32'hC0, 32'h0);
        chk(r, 32'h0);
        bus(1'b1, 32'hC8, 32'h0);
        bus(1'b1, 32'h70, 32'hA0);
        smp(12'hF38);
        chk({low_detect, fifo_low_event, alert_n, irq}, 4'hC);
        bus(1'b0, 32'hC0, 32'h0);
        chk(r, 32'h2);
        smp(12'h000);
        bus(1'b1, 32'hC4, 32'hF);
        bus(1'b1, 32'h70, 32'h90);
        @(posedge hclk);
        conversion_error <= 1'b1;
        @(posedge hclk);
        conversion_error <= 1'b0;
        #1;
        chk({fifo_low_event, fifo_high_event, alert_n}, 3'h0);
        bus(1'b0, 32'hC0, 32'h0);
        chk(r, 32'h4);
        bus(1'b1, 32'h70, 32'h03);
        @(posedge hclk);
        capture_done    <= 1'b1;
        fifo_event_addr <= 15'h123;
        @(posedge hclk);
        capture_done <= 1'b0;
        bus(1'b0, 32'h74, 32'h0);
        chk(r, 32'h123);
        bus(1'b1, 32'h74, 32'h8);
        bus(1'b0, 32'h74, 32'h0);
        chk(r, 32'h8);
        rst;
        foreach (rows[i]) begin
            bus(1'b0, rows[i].a, 32'h0);
            chk(r, (rows[i].a == 32'h74) ? 32'h4000 : 32'h0);
        end
        chk({alert_n, irq, capture_count}, 17'h14000);
        close_out;
    end
endmodule

bind event_fifo_config_regs event_fifo_config_regs_chk chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .result_valid(result_valid), .result_data(result_data),
    .conversion_error(conversion_error), .event_detect_enable(event_detect_enable),
    .high_detect(high_detect), .low_detect(low_detect), .fifo_high_event(fifo_high_event),
    .fifo_low_event(fifo_low_event), .fifo_mode(fifo_mode), .capture_count(capture_count),
    .upper_limit_value(upper_limit_value), .lower_limit_value(lower_limit_value),
    .alert_n(alert_n), .irq(irq));
